// ==== design/flash_cmd_core.sv ====
`timescale 1ns/1ps
// Summary of operation
// R1: opcodes C7h and 60h start whole-array erase, leaving all bytes FFh.
// R2: erase accepted only while the write enable latch is set.
// R3: chip select must rise right after the eighth opcode bit, else erase dropped.
// R4: chip select rise starts timed erase; busy flag high during it.
// R5: write enable latch clears before the erase finishes.
// R6: erase runs only when all four protect bits are zero.
// R7: deep sleep entered only by B9h; plain deselect stays standby.
// R8: power-down executes only if chip select rises after eighth bit.
// R9: deep sleep reached only after the sleep entry delay.
// R10: in deep sleep every opcode except ABh is ignored; 38h and FFh still switch quad mode.
// R11: power-down during a running cycle is rejected, cycle unaffected.
// R12: power-up always lands in standby.
// R13: ABh alone wakes the device after the short wake delay.
// R14: host keeps chip select high through the short wake delay.
// R15: ABh plus three dummy bytes shifts device ID out MSB first.
// R16: device ID byte repeats while chip select stays low.
// R17: ID read from deep sleep delays standby by the shorter ID wake delay.
// R18: ID read outside deep sleep returns to standby at once.
// R19: ID opcode during a running cycle is not decoded.
// R20: opcode 90h with address zero outputs manufacturer then device ID.
// R21: address 000001h swaps order: device ID first.
// R22: after 38h, erase and ID read also work four bits wide.
// R23: opcode, address and dummy bits captured on rising serial clock.
// R24: bits assembled most significant first.
// R25: erase or power-down with extra bits is ignored.
module flash_cmd_core
    import flash_cmd_pkg::*;
#(
    parameter int ERASE_TIME_US = 100000,
    // identity bytes, values arbitrary
    parameter logic [7:0] MANUF_ID = 8'hA5,
    parameter logic [7:0] DEVICE_ID = 8'h5A
)(
    input wire logic clk,
    input wire logic clk_en,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] dq_in,
    output logic [3:0] dq_out,
    output logic [3:0] dq_oe,
    input wire protect_t protect_bits,
    output flash_status_t status,
    output logic array_erase
);

    localparam int ERASE_CYC = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // link side, serial clock domain
    // ------------------------------------------------------------
    logic link_rst_reg;
    logic frame_rst;
    logic started_reg;
    logic quad_pend_reg;
    logic quad_active_reg;
    logic quad_now;
    logic [5:0] bits_reg;
    logic [5:0] bits_base;
    logic [5:0] step;
    logic [5:0] bits_next;
    logic [7:0] op_reg;
    logic [7:0] op_base;
    logic [7:0] op_next;
    logic [23:0] addr_reg;
    logic [23:0] addr_base;
    logic busy_l1_reg;
    logic busy_l2_reg;
    logic sleep_l1_reg;
    logic sleep_l2_reg;
    logic [3:0] idx_reg;
    logic [15:0] pattern;
    logic [15:0] pattern_rot;
    logic out_ok;

    function automatic logic [7:0] shift8(input logic [7:0] old, input logic [3:0] din, input logic quad);
        shift8 = quad ? {old[3:0], din} : {old[6:0], din[0]};
    endfunction

    function automatic logic [23:0] shift24(input logic [23:0] old, input logic [3:0] din, input logic quad);
        shift24 = quad ? {old[19:0], din} : {old[22:0], din[0]};
    endfunction

    // frame state is cleared the moment chip select rises; sclk may be stopped
    assign frame_rst = cs_n | link_rst_reg;

    always_ff @(posedge sclk or posedge frame_rst)
    begin
        if (frame_rst)
            started_reg <= 1'b0;
        else
            started_reg <= 1'b1;
    end

    always_comb
    begin
        quad_now = started_reg ? quad_active_reg : quad_pend_reg;
        bits_base = started_reg ? bits_reg : 6'h00;
        op_base = started_reg ? op_reg : 8'h00;
        addr_base = started_reg ? addr_reg : 24'h00_0000;
        step = quad_now ? STEP_QUAD : STEP_SINGLE; // R22
        bits_next = (bits_base > BITS_MAX - step) ? BITS_MAX : bits_base + step;
        op_next = shift8(op_base, dq_in, quad_now); // R24
    end

    // captured fields persist after the frame; the core reads them only after
    // the synchronised chip select rise, when sclk is quiet
    always_ff @(posedge sclk)
    begin
        bits_reg <= bits_next; // R23
        if (bits_base < BITS_OPCODE)
            op_reg <= op_next; // R24
        else if (bits_base < BITS_HEADER)
            addr_reg <= shift24(addr_base, dq_in, quad_now); // R24
    end

    // quad mode takes effect from the next frame
    always_ff @(posedge sclk or posedge link_rst_reg)
    begin
        if (link_rst_reg)
        begin
            quad_pend_reg <= 1'b0;
            quad_active_reg <= 1'b0;
        end
        else
        begin
            quad_active_reg <= quad_now;
            if (bits_next == BITS_OPCODE && op_next == OP_QUAD_ENABLE)
                quad_pend_reg <= 1'b1; // R22
            else if (bits_next == BITS_OPCODE && op_next == OP_QUAD_EXIT)
                quad_pend_reg <= 1'b0;
        end
    end

    // busy and sleep only gate output after 32 header bits, so two sclk edges settle them
    always_ff @(posedge sclk or posedge link_rst_reg)
    begin
        if (link_rst_reg)
        begin
            busy_l1_reg <= 1'b0;
            busy_l2_reg <= 1'b0;
            sleep_l1_reg <= 1'b0;
            sleep_l2_reg <= 1'b0;
        end
        else
        begin
            busy_l1_reg <= status.busy_flag;
            busy_l2_reg <= busy_l1_reg;
            sleep_l1_reg <= status.deep_sleep;
            sleep_l2_reg <= sleep_l1_reg;
        end
    end

    always_comb
    begin
        if (op_reg == OP_MANUF_DEV_ID && addr_reg != ADDR_SWAP_ORDER)
            pattern = {MANUF_ID, DEVICE_ID}; // R20
        else if (op_reg == OP_MANUF_DEV_ID)
            pattern = {DEVICE_ID, MANUF_ID}; // R21
        else
            pattern = {DEVICE_ID, DEVICE_ID}; // R15
        pattern_rot = pattern << idx_reg;
        out_ok = started_reg && bits_reg >= BITS_HEADER && !busy_l2_reg
            && (op_reg == OP_WAKE_AND_ID || (op_reg == OP_MANUF_DEV_ID && !sleep_l2_reg)); // R19 R10
    end

    always_ff @(negedge sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            dq_out <= 4'h0;
            dq_oe <= 4'h0;
            idx_reg <= 4'h0;
        end
        else if (out_ok)
        begin
            dq_out <= quad_active_reg ? pattern_rot[15:12] : {2'b00, pattern_rot[15], 1'b0}; // R15
            dq_oe <= quad_active_reg ? OE_QUAD : OE_SINGLE;
            idx_reg <= idx_reg + (quad_active_reg ? IDX_STEP_QUAD : IDX_STEP_SINGLE); // R16
        end
    end

    // ------------------------------------------------------------
    // core side, system clock domain
    // ------------------------------------------------------------
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic quad_s1_reg;
    logic quad_s2_reg;
    logic cs_rise;
    logic len8;
    logic is_erase;
    logic erase_ok;
    logic sleep_ok;
    core_state_t state_reg;
    logic [31:0] timer_reg;
    logic wel_reg;
    logic busy_reg;
    logic sleep_reg;
    logic erase_pulse_reg;

    always_ff @(posedge clk)
    begin
        link_rst_reg <= sys_rst;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            quad_s1_reg <= 1'b0;
            quad_s2_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            quad_s1_reg <= quad_pend_reg;
            quad_s2_reg <= quad_s1_reg;
        end
    end

    always_comb
    begin
        cs_rise = cs_s2_reg && !cs_s3_reg;
        len8 = bits_reg == BITS_OPCODE; // R3 R8 R25
        is_erase = op_reg == OP_CHIP_ERASE_A || op_reg == OP_CHIP_ERASE_B; // R1
        erase_ok = cs_rise && len8 && is_erase && wel_reg && protect_bits == 4'h0
            && state_reg == ST_STANDBY; // R2 R6
        sleep_ok = cs_rise && len8 && op_reg == OP_DEEP_SLEEP && state_reg == ST_STANDBY; // R7 R11
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_STANDBY; // R12
            timer_reg <= 32'h0000_0000;
            busy_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            unique case (state_reg)
                ST_STANDBY: // R18
                begin
                    if (erase_ok)
                    begin
                        state_reg <= ST_ERASING; // R4
                        timer_reg <= 32'(ERASE_CYC);
                        busy_reg <= 1'b1; // R4
                    end
                    else if (sleep_ok)
                    begin
                        state_reg <= ST_SLEEP_ENTRY; // R9
                        timer_reg <= 32'(SLEEP_ENTRY_CYC);
                    end
                end
                ST_ERASING:
                begin
                    if (timer_reg <= 32'h0000_0001)
                    begin
                        state_reg <= ST_STANDBY;
                        busy_reg <= 1'b0; // R4
                    end
                    else
                        timer_reg <= timer_reg - 32'h0000_0001;
                end
                ST_SLEEP_ENTRY:
                begin
                    if (timer_reg <= 32'h0000_0001)
                    begin
                        state_reg <= ST_SLEEPING;
                        sleep_reg <= 1'b1; // R9
                    end
                    else
                        timer_reg <= timer_reg - 32'h0000_0001;
                end
                ST_SLEEPING:
                begin
                    if (cs_rise && op_reg == OP_WAKE_AND_ID && bits_reg >= BITS_OPCODE) // R10
                    begin
                        state_reg <= ST_WAKING;
                        timer_reg <= len8 ? 32'(WAKE_SHORT_CYC) : 32'(WAKE_ID_CYC); // R13 R17
                    end
                end
                ST_WAKING:
                begin
                    if (timer_reg <= 32'h0000_0001)
                    begin
                        state_reg <= ST_STANDBY;
                        sleep_reg <= 1'b0; // R13
                    end
                    else
                        timer_reg <= timer_reg - 32'h0000_0001;
                end
                default:
                begin
                    state_reg <= ST_STANDBY;
                end
            endcase
        end
    end

    // write enable latch; erase start clears it well before the cycle ends
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wel_reg <= 1'b0;
        else if (clk_en)
        begin
            if (erase_ok)
                wel_reg <= 1'b0; // R5
            else if (cs_rise && len8 && state_reg == ST_STANDBY && op_reg == OP_WRITE_ENABLE)
                wel_reg <= 1'b1; // R2
            else if (cs_rise && len8 && state_reg == ST_STANDBY && op_reg == OP_WRITE_DISABLE)
                wel_reg <= 1'b0;
        end
    end

    // one-cycle request to the array to set every bit to one
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            erase_pulse_reg <= 1'b0;
        else if (clk_en)
            erase_pulse_reg <= erase_ok; // R1
    end

    assign status = '{busy_flag: busy_reg, write_enable_latch: wel_reg,
                      deep_sleep: sleep_reg, four_wire_command_mode: quad_s2_reg};
    assign array_erase = erase_pulse_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_erase_start;
        @(posedge clk) disable iff (sys_rst) clk_en && erase_ok |=> busy_reg && erase_pulse_reg;
    endproperty
    a_erase_start: assert property (p_erase_start) else $error("erase not started"); // R4

    property p_erase_needs_wel;
        @(posedge clk) disable iff (sys_rst) $rose(erase_pulse_reg) |-> $past(wel_reg);
    endproperty
    a_erase_needs_wel: assert property (p_erase_needs_wel) else $error("erase without latch"); // R2

    property p_wel_cleared;
        @(posedge clk) disable iff (sys_rst) $rose(busy_reg) |-> !wel_reg ##1 !wel_reg;
    endproperty
    a_wel_cleared: assert property (p_wel_cleared) else $error("latch not cleared"); // R5

    property p_protect;
        @(posedge clk) disable iff (sys_rst) cs_rise && is_erase && protect_bits != 4'h0 |=> !erase_pulse_reg;
    endproperty
    a_protect: assert property (p_protect) else $error("protected erase ran"); // R6

    property p_erase_len;
        @(posedge clk) disable iff (sys_rst) cs_rise && is_erase && !len8 |=> !erase_pulse_reg;
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("bad length erase ran"); // R3

    property p_sleep_delay;
        @(posedge clk) disable iff (sys_rst) clk_en && sleep_ok |=> !sleep_reg [*8];
    endproperty
    a_sleep_delay: assert property (p_sleep_delay) else $error("sleep entered early"); // R9

    property p_busy_keeps_cycle;
        @(posedge clk) disable iff (sys_rst)
            state_reg == ST_ERASING && cs_rise && timer_reg > 32'h0000_0001 |=> state_reg == ST_ERASING;
    endproperty
    a_busy_keeps_cycle: assert property (p_busy_keeps_cycle) else $error("cycle disturbed"); // R11

    property p_sleep_ignores;
        @(posedge clk) disable iff (sys_rst)
            state_reg == ST_SLEEPING && cs_rise && op_reg != OP_WAKE_AND_ID |=> state_reg == ST_SLEEPING;
    endproperty
    a_sleep_ignores: assert property (p_sleep_ignores) else $error("sleep left on other opcode"); // R10

    property p_wake;
        @(posedge clk) disable iff (sys_rst)
            clk_en && state_reg == ST_SLEEPING && cs_rise && op_reg == OP_WAKE_AND_ID && len8
            |=> state_reg == ST_WAKING && sleep_reg;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not started"); // R13

    property p_standby_id;
        @(posedge clk) disable iff (sys_rst)
            state_reg == ST_STANDBY && cs_rise && op_reg == OP_WAKE_AND_ID |=> state_reg == ST_STANDBY;
    endproperty
    a_standby_id: assert property (p_standby_id) else $error("standby left on id read"); // R18

endmodule

// ==== design/flash_cmd_pkg.sv ====
package flash_cmd_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE_AND_ID = 8'hAB;
    localparam logic [7:0] OP_MANUF_DEV_ID = 8'h90;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_QUAD_ENABLE = 8'h38;
    localparam logic [7:0] OP_QUAD_EXIT = 8'hFF;

    // ------------------------------------------------------------
    // frame geometry, counted in received bits
    // ------------------------------------------------------------
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_HEADER = 6'h20;
    localparam logic [5:0] BITS_MAX = 6'h3F;
    localparam logic [5:0] STEP_SINGLE = 6'h01;
    localparam logic [5:0] STEP_QUAD = 6'h04;
    localparam logic [3:0] IDX_STEP_SINGLE = 4'h1;
    localparam logic [3:0] IDX_STEP_QUAD = 4'h4;
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_QUAD = 4'hF;
    localparam logic [23:0] ADDR_SWAP_ORDER = 24'h00_0001;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int SLEEP_ENTRY_NS = 3000;
    localparam int WAKE_SHORT_NS = 3000;
    localparam int WAKE_ID_NS = 1800;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_SHORT_CYC = (WAKE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_ID_CYC = (WAKE_ID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STANDBY = 3'h0,
        ST_ERASING = 3'h1,
        ST_SLEEP_ENTRY = 3'h2,
        ST_SLEEPING = 3'h3,
        ST_WAKING = 3'h4
    } core_state_t;

    typedef struct packed {
        logic protect_bit_3;
        logic protect_bit_2;
        logic protect_bit_1;
        logic protect_bit_0;
    } protect_t;

    typedef struct packed {
        logic busy_flag;
        logic write_enable_latch;
        logic deep_sleep;
        logic four_wire_command_mode;
    } flash_status_t;

endpackage

// ==== verification/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model
(
    output logic sclk,
    output logic cs_n,
    output logic [3:0] host_dq,
    input wire logic [3:0] dq
);
    // serial clock only toggles inside a frame, idle low
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_dq = 4'h0;
    end

    // ------------------------------------------------------------
    // one frame: header shifted out, then nr bits read back
    // ------------------------------------------------------------
    task automatic frame(input logic [31:0] hdr, input int nb, input int nr, input bit q,
                         output logic [15:0] rd);
        int w;
        w = q ? 4 : 1;
        rd = 16'h0000;
        #7 cs_n = 1'b0;
        for (int i = 0; i < nb; i += w)
        begin
            // released lines toggle so a stale level never looks valid
            host_dq = q ? hdr[31-i -: 4] : {~host_dq[3:1], hdr[31-i]};
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        for (int j = 0; j < nr; j += w)
        begin
            host_dq = ~host_dq;
            #24 rd = q ? {rd[11:0], dq} : {rd[14:0], dq[1]};
            sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        #24 cs_n = 1'b1;
        host_dq = ~host_dq;
    endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import flash_cmd_pkg::*;
;
    localparam logic [7:0] MAN = 8'h3C; // arbitrary
    localparam logic [7:0] DEV = 8'h96; // arbitrary
    localparam int LIMIT = 60000;

    logic clk;
    logic sys_rst;
    logic clk_en;
    logic sclk;
    logic cs_n;
    logic [3:0] host_dq;
    logic [3:0] dq_out;
    logic [3:0] dq_oe;
    wire [3:0] dq;
    protect_t protect_bits;
    flash_status_t st;
    logic array_erase;
    logic [15:0] rd;
    logic [15:0] pulses;
    logic [15:0] exp_pulses;
    logic oe_seen;
    logic [31:0] r;
    logic [7:0] op;
    int seed;
    int mismatches;
    int total_checks;
    int cyc;
    int n;

    for (genvar i = 0; i < 4; i++)
    begin : g_wire
        assign dq[i] = dq_oe[i] ? dq_out[i] : host_dq[i];
    end

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    flash_cmd_core #(.ERASE_TIME_US(3), .MANUF_ID(MAN), .DEVICE_ID(DEV)) i_dut (
        .clk(clk),
        .clk_en(clk_en),
        .sys_rst(sys_rst),
        .sclk(sclk),
        .cs_n(cs_n),
        .dq_in(dq),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .protect_bits(protect_bits),
        .status(st),
        .array_erase(array_erase)
    );

    spi_host_model i_host (
        .sclk(sclk),
        .cs_n(cs_n),
        .host_dq(host_dq),
        .dq(dq)
    );

    initial pulses = 16'h0000;
    always @(posedge clk) if (array_erase === 1'b1) pulses <= pulses + 16'h0001;
    always @(posedge sclk) if (|dq_oe) oe_seen = 1'b1;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wt(input int k);
        repeat (k) @(negedge clk);
    endtask

    // gap of 8 cycles covers the cs_n sync plus evaluation
    task automatic go(input logic [7:0] o, input logic [23:0] a, input int nb, input int nr, input bit q);
        oe_seen = 1'b0;
        i_host.frame({o, a}, nb, nr, q, rd);
        wt(8);
    endtask

    task automatic wait_idle;
        n = 0;
        while (st.busy_flag === 1'b1 && n < 800)
        begin
            wt(1);
            n++;
        end
    endtask

    function automatic logic [15:0] id_pair(input bit swap);
        return swap ? {DEV, MAN} : {MAN, DEV};
    endfunction

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 94;
        cyc = 0;
        exp_pulses = 16'h0000;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        protect_bits = 4'h0;
        wt(12);
        sys_rst = 1'b0;
        wt(4);
        check(st, 4'h0);
        check(dq_oe, 4'h0);
        go(OP_WRITE_ENABLE, 24'h00_0000, 8, 0, 0);
        go(OP_WRITE_DISABLE, 24'h00_0000, 8, 0, 0);
        check(st.write_enable_latch, 1'b0);
        go(OP_CHIP_ERASE_A, 24'h00_0000, 8, 0, 0);
        check(st.busy_flag, 1'b0);
        check(pulses, exp_pulses);
        $display("test reset_and_no_latch done");
        for (int k = 0; k < 2; k++)
        begin
            op = k ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A;
            r = $random(seed);
            protect_bits = (r[3:0] == 4'h0) ? 4'h8 : r[3:0];
            go(OP_WRITE_ENABLE, 24'h00_0000, 8, 0, 0);
            check(st.write_enable_latch, 1'b1);
            go(op, 24'h00_0000, 8, 0, 0);
            check(st.busy_flag, 1'b0);
            check(pulses, exp_pulses);
            protect_bits = 4'h0;
            go(op, r[31:8], 9 + int'(r[6:4]), 0, 0);
            check(st.busy_flag, 1'b0);
            check(st.write_enable_latch, 1'b1);
            go(op, 24'h00_0000, 8, 0, 0);
            exp_pulses++;
            check(st.busy_flag, 1'b1);
            check(st.write_enable_latch, 1'b0);
            check(pulses, exp_pulses);
            go(OP_DEEP_SLEEP, 24'h00_0000, 8, 0, 0);
            check(st.deep_sleep, 1'b0);
            go(OP_WAKE_AND_ID, 24'h00_0000, 32, 8, 0);
            check(oe_seen, 1'b0);
            check(st.busy_flag, 1'b1);
            wait_idle();
            check(st.busy_flag, 1'b0);
            check(st.deep_sleep, 1'b0);
            $display("test erase_%0d done", k);
        end
        r = $random(seed);
        go(OP_WAKE_AND_ID, r[23:0], 32, 16, 0);
        check(rd, {DEV, DEV});
        check(st.deep_sleep, 1'b0);
        for (int q = 0; q < 2; q++)
        begin
            if (q == 1)
            begin
                go(OP_QUAD_ENABLE, 24'h00_0000, 8, 0, 0);
                check(st.four_wire_command_mode, 1'b1);
            end
            for (int a = 0; a < 2; a++)
            begin
                go(OP_MANUF_DEV_ID, {23'h00_0000, a[0]}, 32, 16, q[0]);
                check(rd, id_pair(a[0]));
            end
        end
        go(OP_WRITE_ENABLE, 24'h00_0000, 8, 0, 1);
        go(OP_CHIP_ERASE_A, 24'h00_0000, 8, 0, 1);
        exp_pulses++;
        check(st.busy_flag, 1'b1);
        check(pulses, exp_pulses);
        wait_idle();
        go(OP_QUAD_EXIT, 24'h00_0000, 8, 0, 1);
        check(st.four_wire_command_mode, 1'b0);
        $display("test id_reads done");
        go(OP_DEEP_SLEEP, 24'h00_0000, 9, 0, 0);
        wt(620);
        check(st.deep_sleep, 1'b0);
        go(OP_WRITE_ENABLE, 24'h00_0000, 8, 0, 0);
        go(OP_DEEP_SLEEP, 24'h00_0000, 8, 0, 0);
        check(st.deep_sleep, 1'b0);
        // a frozen core must not run down the entry delay
        clk_en = 1'b0;
        wt(620);
        check(st.deep_sleep, 1'b0);
        clk_en = 1'b1;
        wt(620);
        check(st.deep_sleep, 1'b1);
        // latch was set before sleeping, so clear and erase must both be ignored
        go(OP_WRITE_DISABLE, 24'h00_0000, 8, 0, 0);
        check(st.write_enable_latch, 1'b1);
        go(OP_CHIP_ERASE_B, 24'h00_0000, 8, 0, 0);
        check(pulses, exp_pulses);
        go(OP_MANUF_DEV_ID, 24'h00_0000, 32, 16, 0);
        check(oe_seen, 1'b0);
        go(OP_WAKE_AND_ID, 24'h00_0000, 8, 0, 0);
        check(st.deep_sleep, 1'b1);
        wt(620);
        check(st.deep_sleep, 1'b0);
        go(OP_DEEP_SLEEP, 24'h00_0000, 8, 0, 0);
        wt(620);
        go(OP_WAKE_AND_ID, 24'h00_0000, 32, 16, 0);
        check(rd, {DEV, DEV});
        check(st.deep_sleep, 1'b1);
        wt(380);
        check(st.deep_sleep, 1'b0);
        $display("test deep_sleep done");
        stop_test();
    end
endmodule
